// ### hdl/mids_pkg.sv
// shared constants and types of the motor input detection stage
package mids_pkg;

  // wishbone register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_ISEL = 8'h04;
  localparam logic [7:0] ADR_FILT = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0c;
  localparam logic [7:0] ADR_CAPT = 8'h10;

  // control register fields
  localparam int CTRL_SR   = 0;
  localparam int CTRL_FREE_RUNNING_SAMPLING = 1;
  localparam int CTRL_PCN  = 2;
  localparam int CTRL_OFF_STATE_HANDLING_BIT = 3;
  localparam int CTRL_DAC  = 4;
  localparam int CTRL_TES  = 5;
  localparam int CTRL_DS   = 8;
  localparam int CTRL_OS   = 12;

  // input select register fields
  localparam int ISEL_PRE = 0;
  localparam int ISEL_ACT = 4;

  // filter register fields
  localparam int FILT_DWIN = 0;
  localparam int FILT_DEVT = 8;
  localparam int FILT_ZWIN = 16;
  localparam int FILT_ZEVT = 24;

  // status register fields
  localparam int STAT_ENCODER_DIRECTION_FLAG  = 0;
  localparam int STAT_SOUT  = 1;
  localparam int STAT_LVL   = 4;
  localparam int STAT_PHASE = 8;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [1:0]  ISEL_RST = 2'h0;
  localparam logic [31:0] FILT_RST = 32'h0101_0101;

  // timing
  localparam int CLK_MHZ    = 250;
  localparam int BLANK_NS   = 1000;
  localparam int SCF_NS     = 1000;
  localparam int DS_STEP_NS = 2500;
  localparam int BLANK_CYC  = (BLANK_NS * CLK_MHZ) / 1000;
  localparam int SCF_CYC    = (SCF_NS * CLK_MHZ) / 1000;
  localparam int DS_STEP_CYC = (DS_STEP_NS * CLK_MHZ) / 1000;

  typedef enum {PH_IDLE, PH_DWIN, PH_DEVT, PH_ZWIN, PH_ZEVT} mids_phase_e;

  typedef struct packed {
    logic [2:0] analog;
    logic [2:0] digital;
    logic [2:0] gpio;
    logic [2:0] grounded;
  } mids_pins_s;

endpackage : mids_pkg

// ### hdl/mids_sync.sv
// three-stage synchroniser with qualified edge pulses
`timescale 1ns/100ps
`default_nettype none
module mids_sync #(
  parameter int W = 3
) (
  // clock, reset, enable
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  // raw pins
  input  wire logic [W-1:0] d_i,
  // filtered level and edges
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  if (W < 1)
  begin : g_bad_w
    $error("mids_sync: width must be positive");
  end

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clk_i)
    begin
      if (!resetn_i)
      begin
        s1_r[i]    <= 1'b0;
        s2_r[i]    <= 1'b0;
        s3_r[i]    <= 1'b0;
        level_o[i] <= 1'b0;
        rise_o[i]  <= 1'b0;
        fall_o[i]  <= 1'b0;
      end
      else if (ce_i)
      begin
        s1_r[i] <= d_i[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        // change counts once stages two and three agree
        if (s2_r[i] == s3_r[i])
          level_o[i] <= s3_r[i];
        rise_o[i] <= (s2_r[i] == s3_r[i]) & s3_r[i] & ~level_o[i];
        fall_o[i] <= (s2_r[i] == s3_r[i]) & ~s3_r[i] & level_o[i];
      end
    end
  end

endmodule : mids_sync
`default_nettype wire

// ### hdl/mids_top.sv
// motor position input detection stage with wishbone registers
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module mids_top
  import mids_pkg::*;
#(
  parameter int SCF_DIV = SCF_CYC,
  parameter int BLANK   = BLANK_CYC,
  parameter int DS_STEP = DS_STEP_CYC
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // position pins and motor events
  input  wire logic [2:0]  position_inputs_i,
  input  wire logic        pwm_on_i,
  input  wire logic        comm_event_i,
  // detection results
  output logic             demag_event_o,
  output logic             zero_cross_event_o,
  output logic             capture_event_o,
  output logic             enc_clk_o,
  output logic             encoder_direction_flag_o,
  output logic             speed_mode_o,
  output logic      [2:0]  output_state_select_o,
  // pin configuration
  output mids_pins_s       pins_o,
  output logic             comparator_on_o
);

  if (SCF_DIV < 1 || SCF_DIV > 65536 || BLANK < 1 || BLANK > 65536 ||
      DS_STEP < 1 || DS_STEP * 15 > 65535)
  begin : g_param_chk
    $error("mids_top: timing parameter out of range");
  end

  function automatic mids_pins_s pin_map(input logic pin_config_bit,
                                         input logic [1:0] tes,
                                         input logic sr,
                                         input logic [1:0] sel,
                                         input logic off_state_handling_bit);
    mids_pins_s p;
    logic [2:0] one;
    p   = '0;
    one = (sel == 2'h3) ? 3'h0 : 3'(3'h1 << sel);
    if (tes == 2'h0)
    begin
      if (sel == 2'h3)
        p.gpio = pin_config_bit ? 3'h7 : 3'h0;
      else if (pin_config_bit || !sr)
      begin
        p.analog = one;
        p.gpio   = pin_config_bit ? ~one : 3'h0;
        p.grounded = (!pin_config_bit && off_state_handling_bit) ? ~one : 3'h0;
      end
      else
      begin
        p.digital = one;
        p.gpio    = ~one;
      end
    end
    else if (sel == 2'h3)
    begin
      p.digital = pin_config_bit ? 3'h0 : 3'h3;
      p.gpio    = pin_config_bit ? 3'h7 : 3'h4;
    end
    else
    begin
      p.digital = one;
      p.gpio    = ~one;
    end
    return p;
  endfunction : pin_map

  // registers
  logic [31:0] ctrl_r;
  logic [1:0]  isel_pre_r;
  logic [1:0]  isel_act_r;
  logic [31:0] filt_r;
  logic [15:0] capt_cnt_r;
  logic        sout_r;

  logic        sr;
  logic        free_running_sampling;
  logic [1:0]  tes;
  logic [3:0]  ds;
  logic        speed;
  logic        wr_go;
  logic        wr_ctrl;
  logic        wr_isel;
  logic        wr_filt;
  logic        wr_stat;
  logic        wr_capt;

  assign sr    = ctrl_r[CTRL_SR];
  assign free_running_sampling  = ctrl_r[CTRL_FREE_RUNNING_SAMPLING];
  assign tes   = ctrl_r[CTRL_TES +: 2];
  assign ds    = ctrl_r[CTRL_DS +: 4];
  assign speed = (tes != 2'h0);

  // bus write strobes at the acknowledging edge
  assign wr_go   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign wr_ctrl = wr_go & (wb_adr_i == ADR_CTRL);
  assign wr_isel = wr_go & (wb_adr_i == ADR_ISEL);
  assign wr_filt = wr_go & (wb_adr_i == ADR_FILT);
  assign wr_stat = wr_go & (wb_adr_i == ADR_STAT);
  assign wr_capt = wr_go & (wb_adr_i == ADR_CAPT);

  // synchronised pins
  logic [2:0] lvl;
  logic [2:0] rise;
  logic [2:0] fall;

  mids_sync #(
    .W(3)
  ) u_sync (
    .clk_i   (clk_i),
    .resetn_i(resetn_i),
    .ce_i    (ce_i),
    .d_i     (position_inputs_i),
    .level_o (lvl),
    .rise_o  (rise),
    .fall_o  (fall)
  );

  // sampling timebase
  logic        pwm_q;
  logic        pwm_edge;
  logic [15:0] blank_cnt_r;
  logic [15:0] scf_cnt_r;
  logic [15:0] dly_cnt_r;
  logic        hf_tick;
  logic        blank;
  logic        dly_hit;
  logic        dly_done_r;
  logic        d_smp;
  logic        z_smp;
  logic        sel_lvl;

  assign pwm_edge = pwm_on_i ^ pwm_q;
  assign hf_tick  = (scf_cnt_r == 16'h0);
  assign blank    = pwm_edge | (blank_cnt_r != 16'h0);
  assign dly_hit  = (dly_cnt_r == 16'h1) & pwm_on_i;
  assign sel_lvl  = (isel_act_r == 2'h3) ? 1'b0 : lvl[isel_act_r];

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pwm_q       <= 1'b0;
      blank_cnt_r <= 16'h0;
      scf_cnt_r   <= 16'h0;
    end
    else if (ce_i)
    begin
      pwm_q <= pwm_on_i;
      if (pwm_edge)
        blank_cnt_r <= 16'(BLANK - 1);
      else if (blank_cnt_r != 16'h0)
        blank_cnt_r <= blank_cnt_r - 16'h1;
      scf_cnt_r <= hf_tick ? 16'(SCF_DIV - 1) : scf_cnt_r - 16'h1;
    end
  end

  // delay before on-time sampling
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      dly_cnt_r  <= 16'h0;
      dly_done_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (pwm_on_i && !pwm_q)
        dly_cnt_r <= 16'(int'(ds) * DS_STEP);
      else if (dly_cnt_r != 16'h0)
        dly_cnt_r <= dly_cnt_r - 16'h1;
      if (!pwm_on_i)
        dly_done_r <= 1'b0;
      else if (dly_hit)
        dly_done_r <= 1'b1;
    end
  end

  // sample strobes per mode
  always_comb
  begin
    d_smp = hf_tick & ~blank;
    if (sr)
      z_smp = hf_tick;
    else if (ds == 4'h0)
      z_smp = free_running_sampling ? (hf_tick & ~blank)
                   : (pwm_on_i & ~pwm_q);
    else
      z_smp = free_running_sampling ? (hf_tick & pwm_on_i & (dly_done_r | dly_hit))
                   : dly_hit;
  end

  // filter sequence
  mids_phase_e phase_r;
  logic [7:0]  win_cnt_r;
  logic [3:0]  evt_cnt_r;
  logic        z_last_r;

  function automatic logic [3:0] evt_need(input logic [3:0] n);
    return (n == 4'h0) ? 4'h1 : n;
  endfunction : evt_need

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      phase_r            <= PH_IDLE;
      win_cnt_r          <= 8'h0;
      evt_cnt_r          <= 4'h0;
      z_last_r           <= 1'b0;
      demag_event_o      <= 1'b0;
      zero_cross_event_o <= 1'b0;
    end
    else if (ce_i)
    begin
      demag_event_o      <= 1'b0;
      zero_cross_event_o <= 1'b0;
      if (speed)
        phase_r <= PH_IDLE;
      else if (sr)
      begin
        phase_r <= PH_IDLE;
        if (z_smp)
        begin
          z_last_r           <= sel_lvl;
          zero_cross_event_o <= (sel_lvl != z_last_r);
        end
      end
      else if (comm_event_i)
      begin
        phase_r   <= PH_DWIN;
        win_cnt_r <= filt_r[FILT_DWIN +: 8];
        evt_cnt_r <= 4'h0;
      end
      else
      begin
        unique case (phase_r)
          PH_IDLE: ;
          PH_DWIN:
            if (win_cnt_r == 8'h0)
              phase_r <= PH_DEVT;
            else if (d_smp)
              win_cnt_r <= win_cnt_r - 8'h1;
          PH_DEVT:
            if (d_smp)
            begin
              evt_cnt_r <= sel_lvl ? evt_cnt_r + 4'h1 : 4'h0;
              if (sel_lvl &&
                  evt_cnt_r + 4'h1 >= evt_need(filt_r[FILT_DEVT +: 4]))
              begin
                demag_event_o <= 1'b1;
                phase_r       <= PH_ZWIN;
                win_cnt_r     <= filt_r[FILT_ZWIN +: 8];
                evt_cnt_r     <= 4'h0;
              end
            end
          PH_ZWIN:
            if (win_cnt_r == 8'h0)
              phase_r <= PH_ZEVT;
            else if (z_smp)
              win_cnt_r <= win_cnt_r - 8'h1;
          PH_ZEVT:
            if (z_smp)
            begin
              evt_cnt_r <= !sel_lvl ? evt_cnt_r + 4'h1 : 4'h0;
              if (!sel_lvl &&
                  evt_cnt_r + 4'h1 >= evt_need(filt_r[FILT_ZEVT +: 4]))
              begin
                zero_cross_event_o <= 1'b1;
                phase_r            <= PH_IDLE;
              end
            end
        endcase
      end
    end
  end

  // speed sensor inputs
  logic tach_rise;
  logic tach_fall;
  logic enc_mode;

  assign enc_mode  = speed & (isel_act_r == 2'h3);
  assign tach_rise = (isel_act_r == 2'h3) ? 1'b0 : rise[isel_act_r];
  assign tach_fall = (isel_act_r == 2'h3) ? 1'b0 : fall[isel_act_r];

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      capture_event_o          <= 1'b0;
      enc_clk_o                <= 1'b0;
      encoder_direction_flag_o <= 1'b0;
    end
    else if (ce_i)
    begin
      capture_event_o <= speed & ~enc_mode &
                         ((tes[0] & tach_rise) | (tes[1] & tach_fall));
      // any edge of either input; one input alone gives half rate
      enc_clk_o <= enc_mode & (|(rise[1:0] | fall[1:0]));
      if (enc_mode && fall[1])
        encoder_direction_flag_o <= lvl[0];
    end
  end

  // register file
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      ctrl_r     <= CTRL_RST;
      isel_pre_r <= ISEL_RST;
      isel_act_r <= ISEL_RST;
      filt_r     <= FILT_RST;
    end
    else if (ce_i)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wr_ctrl && wb_sel_i[b])
          ctrl_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        if (wr_filt && wb_sel_i[b])
          filt_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
      end
      if (wr_isel && wb_sel_i[0])
        isel_pre_r <= wb_dat_i[ISEL_PRE +: 2];
      if (wr_isel && wb_sel_i[0] && ctrl_r[CTRL_DAC])
        isel_act_r <= wb_dat_i[ISEL_PRE +: 2];
      else if (comm_event_i)
        isel_act_r <= isel_pre_r;
    end
  end

  // status and capture counter
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      sout_r     <= 1'b0;
      capt_cnt_r <= 16'h0;
    end
    else if (ce_i)
    begin
      // late delayed sample: set wins over clear
      if (!sr && ds != 4'h0 && !pwm_on_i && pwm_q && !dly_done_r)
        sout_r <= 1'b1;
      else if (wr_stat && wb_sel_i[0] && wb_dat_i[STAT_SOUT])
        sout_r <= 1'b0;
      if (capture_event_o || enc_clk_o)
        capt_cnt_r <= capt_cnt_r + 16'h1;
      else if (wr_capt)
        capt_cnt_r <= 16'h0;
    end
  end

  // pin map and output state
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pins_o                <= '0;
      comparator_on_o       <= 1'b0;
      speed_mode_o          <= 1'b0;
      output_state_select_o <= 3'h0;
    end
    else if (ce_i)
    begin
      pins_o <= pin_map(ctrl_r[CTRL_PCN], tes, sr, isel_act_r,
                        ctrl_r[CTRL_OFF_STATE_HANDLING_BIT]);
      comparator_on_o <= (tes == 2'h0) & (isel_act_r != 2'h3) &
                         (ctrl_r[CTRL_PCN] | ~sr);
      speed_mode_o <= speed;
      output_state_select_o <= ctrl_r[CTRL_OS +: 3] &
                               (sr ? 3'h5 : 3'h7);
    end
  end

  // wishbone answer
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h0;
      unique case (wb_adr_i)
        ADR_CTRL: wb_dat_o <= ctrl_r;
        ADR_ISEL: wb_dat_o <= {26'h0, isel_act_r, 2'h0, isel_pre_r};
        ADR_FILT: wb_dat_o <= filt_r;
        ADR_STAT: wb_dat_o <= {21'h0, 3'(phase_r), 1'b0, lvl,
                               2'h0, sout_r, encoder_direction_flag_o};
        ADR_CAPT: wb_dat_o <= {16'h0, capt_cnt_r};
        default:  wb_dat_o <= 32'h0;
      endcase
    end
  end

endmodule : mids_top
`default_nettype wire

// ### testbench/mids_top_monitor.sv
// port checker for the motor input detection stage
`timescale 1ns/100ps
`default_nettype none
module mids_top_monitor
  import mids_pkg::*;
#(
  parameter int SCF_DIV = SCF_CYC,
  parameter int BLANK   = BLANK_CYC,
  parameter int DS_STEP = DS_STEP_CYC
) (
  // clock, reset, enable
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        ce_i,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // pins and results
  input wire logic [2:0]  position_inputs_i,
  input wire logic        pwm_on_i,
  input wire logic        comm_event_i,
  input wire logic        demag_event_o,
  input wire logic        zero_cross_event_o,
  input wire logic        capture_event_o,
  input wire logic        enc_clk_o,
  input wire logic        encoder_direction_flag_o,
  input wire logic        speed_mode_o,
  input wire logic [2:0]  output_state_select_o,
  input wire mids_pins_s  pins_o,
  input wire logic        comparator_on_o
);
  logic [15:0] ctrl_r;
  logic [1:0]  age_r;
  logic [3:0]  bfall_r;
  logic [3:0]  edge_r;
  logic [2:0]  pin_r;
  logic        wr_ctrl;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  assign wr_ctrl = ce_i && wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i
                   && wb_adr_i == ADR_CTRL;

  // shadow of control fields and its age
  always_ff @(posedge clk_i)
    if (!resetn_i)
      ctrl_r <= '0;
    else if (wr_ctrl)
      ctrl_r <= wb_dat_i[15:0];

  always_ff @(posedge clk_i)
    if (!resetn_i || wr_ctrl)
      age_r <= '0;
    else if (age_r != 2'd3)
      age_r <= age_r + 2'd1;

  // cycles since a raw pin edge
  always_ff @(posedge clk_i)
    pin_r <= position_inputs_i;

  always_ff @(posedge clk_i)
    if (!resetn_i)
    begin
      bfall_r <= 4'hf;
      edge_r  <= 4'hf;
    end
    else
    begin
      bfall_r <= (pin_r[1] && !position_inputs_i[1]) ? 4'h0
                 : bfall_r + {3'h0, bfall_r != 4'hf};
      edge_r  <= (pin_r != position_inputs_i) ? 4'h0
                 : edge_r + {3'h0, edge_r != 4'hf};
    end

  ack_timing_a: assert property (
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_zero_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i > ADR_CAPT |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  speed_mode_a: assert property (
    age_r == 2'd3 |-> speed_mode_o == (ctrl_r[6:5] != 2'h0))
    else $error("speed mode differs from edge select");
  os_mask_a: assert property (
    age_r == 2'd3 |-> output_state_select_o
      == (ctrl_r[14:12] & {1'b1, !ctrl_r[0], 1'b1}))
    else $error("output state select wrong");
  capture_mode_a: assert property (
    capture_event_o |-> speed_mode_o)
    else $error("capture outside speed mode");
  enc_mode_a: assert property (enc_clk_o |-> speed_mode_o)
    else $error("encoder clock outside speed mode");
  dir_cause_a: assert property (
    $changed(encoder_direction_flag_o) |-> bfall_r < 4'ha)
    else $error("direction moved without b falling");
  enc_cause_a: assert property (enc_clk_o |-> edge_r < 4'ha)
    else $error("encoder clock without pin edge");
  detect_mode_a: assert property (
    demag_event_o || zero_cross_event_o |-> !speed_mode_o)
    else $error("motor event in speed mode");

  cover property (enc_clk_o);
  cover property (capture_event_o);
  cover property ($rose(encoder_direction_flag_o));
  cover property (demag_event_o);
endmodule : mids_top_monitor

bind mids_top mids_top_monitor #(
  .SCF_DIV(SCF_DIV),
  .BLANK(BLANK),
  .DS_STEP(DS_STEP)
) u_mon (.*);
`default_nettype wire

// ### testbench/mids_sensor_model.sv
// behavioural encoder and tachogenerator on the position pins
`timescale 1ns/100ps
`default_nettype none
module mids_sensor_model #(
  parameter int HP = 12
) (
  // clock and commands
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic       rev_i,
  input  wire logic       one_i,
  // position pins
  output logic      [2:0] pins_o
);
  int         cnt_r = 0;
  logic [1:0] ph_r  = 2'h0;

  // one quadrature step every HP cycles
  always @(posedge clk_i)
    if (run_i)
    begin
      cnt_r <= (cnt_r == HP - 1) ? 0 : cnt_r + 1;
      if (cnt_r == HP - 1)
        ph_r <= rev_i ? ph_r - 2'h1 : ph_r + 2'h1;
    end

  // a and b a quarter period apart, b pulled low if absent
  assign pins_o = {ph_r[0], ph_r[1] & !one_i, ph_r[0] ^ ph_r[1]};
endmodule : mids_sensor_model
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench of the motor input detection stage
`timescale 1ns/100ps
`default_nettype none
module testbench
  import mids_pkg::*;
;
  logic        clk_i, resetn_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat, r;
  logic        wb_ack_o, pwm_on_i, comm_event_i, run, rev, one;
  logic [2:0]  position_inputs_i, output_state_select_o;
  logic        capture_event_o, enc_clk_o, encoder_direction_flag_o;
  logic        speed_mode_o, comparator_on_o;
  logic        demag_event_o, zero_cross_event_o;
  logic [1:0]  tes, is;
  mids_pins_s  pins_o;
  int          bad_count = 0, cmp_count = 0, pulse_n = 0, cyc_n = 0;
  int          seed;

  mids_top #(.SCF_DIV(4), .BLANK(2), .DS_STEP(3)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .position_inputs_i(position_inputs_i), .pwm_on_i(pwm_on_i),
    .comm_event_i(comm_event_i), .demag_event_o(demag_event_o),
    .zero_cross_event_o(zero_cross_event_o),
    .capture_event_o(capture_event_o),
    .enc_clk_o(enc_clk_o),
    .encoder_direction_flag_o(encoder_direction_flag_o),
    .speed_mode_o(speed_mode_o),
    .output_state_select_o(output_state_select_o),
    .pins_o(pins_o), .comparator_on_o(comparator_on_o));

  mids_sensor_model #(.HP(12)) u_sens (.clk_i(clk_i), .run_i(run),
    .rev_i(rev), .one_i(one), .pins_o(position_inputs_i));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task test_done;
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one classic wishbone cycle, read data left in rdat
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic cfg(input logic [15:0] c, input logic [1:0] s);
    // pin config bit held clear while the select moves
    wb(ADR_CTRL, 1'b1,
       {16'h0, c & ~(16'h1 << CTRL_PCN)} | (32'h1 << CTRL_DAC));
    wb(ADR_ISEL, 1'b1, {30'h0, s});
    wb(ADR_CTRL, 1'b1, {16'h0, c} | (32'h1 << CTRL_DAC));
  endtask : cfg

  // sixteen sensor steps, pulses counted meanwhile
  task automatic spin(input logic rv, input logic on);
    rev <= rv;
    one <= on;
    repeat (10) @(posedge clk_i);
    pulse_n = 0;
    run <= 1'b1;
    repeat (16 * 12) @(posedge clk_i);
    run <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask : spin

  function automatic int exp_pulses(input logic [1:0] t,
                                    input logic [1:0] s, input logic o);
    if (s == 2'h3)
      return o ? 8 : 16;
    return (t == 2'h3) ? 8 : 4;
  endfunction : exp_pulses

  function automatic logic cmp_exp(input logic pin_config_bit, sr,
                                   input logic [1:0] t, s);
    return t == 2'h0 && s != 2'h3 && (pin_config_bit || !sr);
  endfunction : cmp_exp

  function automatic mids_pins_s pins_exp(input logic pin_config_bit, sr, off_state_handling_bit,
                                          input logic [1:0] t, s);
    mids_pins_s p;
    logic [2:0] oh;
    p = '0;
    oh = 3'h1 << s;
    if (s == 2'h3)
    begin
      if (t != 2'h0)
        p.digital = pin_config_bit ? 3'h0 : 3'h3;
      if (t != 2'h0 || pin_config_bit)
        p.gpio = (pin_config_bit) ? 3'h7 : 3'h4;
    end
    else if (t != 2'h0 || (sr && !pin_config_bit))
    begin
      p.digital = oh;
      p.gpio = ~oh;
    end
    else
    begin
      p.analog = oh;
      if (pin_config_bit)
        p.gpio = ~oh;
      else if (off_state_handling_bit)
        p.grounded = ~oh;
    end
    return p;
  endfunction : pins_exp

  always @(posedge clk_i)
  begin
    if (capture_event_o === 1'b1 || enc_clk_o === 1'b1 ||
        demag_event_o === 1'b1 || zero_cross_event_o === 1'b1)
      pulse_n++;
    cyc_n++;
    if (cyc_n == 20000)
    begin
      bad_count++;
      test_done();
    end
  end

  initial
  begin
    seed = 48;
    {resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, run, rev, one} = '0;
    {pwm_on_i, comm_event_i, wb_adr_i, wb_dat_i} = '0;
    ce_i = 1'b1;
    wb_sel_i = 4'hf;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    wb(ADR_CTRL, 1'b0, 32'h0);
    chk(rdat, CTRL_RST);
    wb(ADR_FILT, 1'b0, 32'h0);
    chk(rdat, FILT_RST);
    wb(8'h40, 1'b1, 32'hffff_ffff);
    wb(8'h40, 1'b0, 32'h0);
    chk(rdat, 32'h0);
    cfg(16'h0, 2'h2);
    wb(ADR_CTRL, 1'b1, 32'h0);
    wb(ADR_ISEL, 1'b1, 32'h1);
    wb(ADR_ISEL, 1'b0, 32'h0);
    chk(rdat, 32'h21);
    comm_event_i <= 1'b1;
    @(posedge clk_i);
    comm_event_i <= 1'b0;
    wb(ADR_ISEL, 1'b0, 32'h0);
    chk(rdat, 32'h11);
    for (int k = 0; k < 6; k++)
    begin
      tes = (k < 3) ? 2'(k + 1) : 2'(k - 2);
      is = (k < 3) ? 2'h0 : 2'h3;
      cfg(16'(tes) << CTRL_TES, is);
      wb(ADR_CAPT, 1'b1, 32'h0);
      spin(k == 3, k == 4);
      chk(pulse_n, exp_pulses(tes, is, k == 4));
      wb(ADR_CAPT, 1'b0, 32'h0);
      chk(rdat, exp_pulses(tes, is, k == 4));
      chk(speed_mode_o, 1'b1);
      if (k == 3 || k == 5)
        chk(encoder_direction_flag_o, k == 3);
    end
    // sensorless, free running: one demag then one zero cross
    cfg(16'h2, 2'h0);
    comm_event_i <= 1'b1;
    @(posedge clk_i);
    comm_event_i <= 1'b0;
    spin(1'b0, 1'b0);
    chk(pulse_n, 2);
    // sensor mode: every level change of pin a is an event
    cfg(16'h1, 2'h0);
    spin(1'b0, 1'b0);
    chk(pulse_n, 8);
    for (int i = 0; i < 24; i++)
    begin
      r = $random(seed);
      pwm_on_i <= r[7];
      cfg({1'b0, r[10:8], 5'h0, r[4:3], 1'b0, r[2:1], 1'b0, r[0]},
          r[6:5]);
      repeat (3) @(posedge clk_i);
      chk(pins_o, pins_exp(r[1], r[0], r[2], r[4:3], r[6:5]));
      chk(output_state_select_o, r[10:8] & {1'b1, !r[0], 1'b1});
      chk(comparator_on_o, cmp_exp(r[1], r[0], r[4:3], r[6:5]));
    end
    test_done();
  end
endmodule : testbench
`default_nettype wire
